// ### tch_baseline.sv
/*
 * Per-sensor baseline tracking with a noise gate and an update bucket.
 * Assumes raw counts arrive on the block clock with a one-cycle valid.
 */
`timescale 1ns/100ps
module tch_baseline #(
	parameter int N = 2,
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	tch_trk_if.trk t
);
	for (genvar i = 0; i < N; i++) begin : g_sns
		logic [W-1:0] bl_q, bl_d, raw, diff;
		logic [8:0] bk_q, bk_d, sum;
		logic seen_q, seen_d, quiet;

		assign raw = t.raw[i*W +: W];
		assign diff = raw - bl_q;
		// Only a positive excursion under the noise limit feeds the bucket
		assign quiet = (raw > bl_q) && (diff < {{(W-8){1'b0}}, t.noise_limit});
		assign sum = bk_q + {1'b0, diff[7:0]};

		always_comb begin
			bl_d = bl_q;
			bk_d = bk_q;
			seen_d = seen_q;
			if (t.valid[i] && t.enable[i]) begin
				if (!seen_q) begin
					// First sample after reset seeds the baseline
					bl_d = raw;
					bk_d = 9'h000;
					seen_d = 1'b1;
				end else if (quiet) begin
					if (sum >= {1'b0, t.bucket_limit}) begin
						bl_d = bl_q + {{(W-1){1'b0}}, 1'b1};
						bk_d = 9'h000;
					end else begin
						bk_d = sum;
					end
				end
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				bl_q <= '0;
				bk_q <= 9'h000;
				seen_q <= 1'b0;
			end else begin
				bl_q <= bl_d;
				bk_q <= bk_d;
				seen_q <= seen_d;
			end
		end

		assign t.baseline[i*W +: W] = bl_q;

		a_noise_gate: assert property (@(posedge clk) disable iff (rst)
			(t.valid[i] && t.enable[i] && seen_q && raw > bl_q
				&& diff >= {{(W-8){1'b0}}, t.noise_limit}) |=> $stable(bl_q))
			else $error("baseline moved on a count above the noise limit");
		a_bucket_step: assert property (@(posedge clk) disable iff (rst)
			(t.valid[i] && t.enable[i] && seen_q && quiet
				&& sum >= {1'b0, t.bucket_limit})
				|=> (bl_q == $past(bl_q) + 1'b1) && (bk_q == 9'h000))
			else $error("full bucket did not step the baseline");
	end
endmodule // tch_baseline

// ### tch_gpo_top.sv
/*
 * Touch controller output logic: configuration registers, per-output
 * AND/OR logic over sensor states, pin drive and baseline tracking.
 * Assumes a serial front end that delivers byte register accesses on clk,
 * and a sensing core that supplies touch states and raw counts on clk.
 */
`timescale 1ns/100ps
`include "tch_map.svh"

module tch_gpo_top #(
	parameter int N = 2,
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register access from the serial front end
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sensing core
	input wire logic [N-1:0] touch_state,
	input wire logic [N*W-1:0] raw_count,
	input wire logic [N-1:0] raw_valid,
	output logic [N*W-1:0] baseline,
	// Output pins
	input wire logic [N-1:0] pin_in,
	output logic [N-1:0] pin_out,
	output logic [N-1:0] pin_oe_n,
	output logic [N-1:0] pin_strong,
	// Mode
	output logic setup_mode
);
	localparam logic [7:0] RST_OUT_LEVEL = `TCH_RST_OUT_LEVEL;
	localparam logic [7:0] RST_SENSE_EN = `TCH_RST_SENSE_EN;
	localparam logic [7:0] RST_OUT_EN = `TCH_RST_OUT_EN;
	localparam logic [7:0] RST_STRONG = `TCH_RST_STRONG;
	localparam logic [7:0] LSEL_OFS [2] = '{`TCH_OFS_LSEL0, `TCH_OFS_LSEL1};
	localparam logic [7:0] LIN_OFS [2] = '{`TCH_OFS_LIN0, `TCH_OFS_LIN1};
	localparam logic [7:0] LIN_RST [2] = '{`TCH_RST_LIN0, `TCH_RST_LIN1};

	// Register state
	tch_pkg::tch_mode_t mode_q, mode_d;
	logic [N-1:0] out_level_q, out_level_d;
	logic [N-1:0] sense_en_q, sense_en_d;
	logic [N-1:0] out_en_q, out_en_d;
	logic [N-1:0] strong_q, strong_d;
	tch_pkg::tch_byte_t lsel_q [N];
	tch_pkg::tch_byte_t lsel_d [N];
	tch_pkg::tch_byte_t lin_q [N];
	tch_pkg::tch_byte_t lin_d [N];
	tch_pkg::tch_byte_t noise_q, noise_d;
	tch_pkg::tch_byte_t bucket_q, bucket_d;
	tch_pkg::tch_byte_t rdata_q, rdata_d;

	// Pin state
	logic [N-1:0] pin_s1_q, pin_s2_q;
	logic [N-1:0] pin_out_q, pin_out_d;
	logic [N-1:0] pin_oe_n_q, pin_oe_n_d;
	logic [N-1:0] pin_strong_q, pin_strong_d;

	logic [N-1:0] live_touch;
	logic [N-1:0] logic_res;
	logic in_setup;

	assign in_setup = (mode_q == tch_pkg::TCH_SETUP);
	// Disabled sensors never report a touch to the output logic
	assign live_touch = touch_state & sense_en_q;

	for (genvar i = 0; i < N; i++) begin : g_logic
		logic [N-1:0] sel, hit;
		logic any_v, all_v, comb_v;

		assign sel = lin_q[i][N-1:0];
		assign hit = live_touch & sel;
		assign any_v = |hit;
		assign all_v = &(live_touch | ~sel);
		assign comb_v = lsel_q[i][`TCH_BIT_LOGIC_AND] ? all_v : any_v;
		assign logic_res[i] = comb_v ^ lsel_q[i][`TCH_BIT_LOGIC_INV];
	end

	// Register writes and mode changes
	always_comb begin
		mode_d = mode_q;
		out_level_d = out_level_q;
		sense_en_d = sense_en_q;
		out_en_d = out_en_q;
		strong_d = strong_q;
		lsel_d = lsel_q;
		lin_d = lin_q;
		noise_d = noise_q;
		bucket_d = bucket_q;
		if (reg_wr) begin
			case (reg_addr)
				`TCH_OFS_OUT_LEVEL: begin
					for (int i = 0; i < N; i++) begin
						// A logic-driven output keeps its stored level untouched
						if (!lsel_q[i][`TCH_BIT_LOGIC_EN]) begin
							out_level_d[i] = reg_wdata[i];
						end
					end
				end
				`TCH_OFS_SENSE_EN: begin
					if (in_setup) begin
						sense_en_d = reg_wdata[N-1:0];
					end
				end
				`TCH_OFS_OUT_EN: begin
					if (in_setup) begin
						out_en_d = reg_wdata[N-1:0];
					end
				end
				`TCH_OFS_STRONG: begin
					if (in_setup) begin
						strong_d = reg_wdata[N-1:0];
					end
				end
				`TCH_OFS_NOISE: begin
					noise_d = reg_wdata;
				end
				`TCH_OFS_BUCKET: begin
					bucket_d = reg_wdata;
				end
				`TCH_OFS_CMD: begin
					if (reg_wdata == `TCH_CMD_SETUP) begin
						mode_d = tch_pkg::TCH_SETUP;
					end else if (reg_wdata == `TCH_CMD_NORMAL) begin
						mode_d = tch_pkg::TCH_NORMAL;
					end
				end
				default: begin
				end
			endcase
			for (int i = 0; i < N; i++) begin
				// Logic select writes while the output is disabled are dropped; input select writes always land
				if (reg_addr == LSEL_OFS[i] && out_en_q[i]) begin
					lsel_d[i] = reg_wdata & `TCH_LSEL_MASK;
				end
				if (reg_addr == LIN_OFS[i]) begin
					lin_d[i] = {{(8-N){1'b0}}, reg_wdata[N-1:0]};
				end
			end
		end
	end

	// Read mux; the write-only level and command registers read as zero
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			rdata_d = 8'h00;
			case (reg_addr)
				`TCH_OFS_STATUS: rdata_d = {{(8-N){1'b0}}, pin_s2_q};
				`TCH_OFS_SENSE_EN: rdata_d = {{(8-N){1'b0}}, sense_en_q};
				`TCH_OFS_OUT_EN: rdata_d = {{(8-N){1'b0}}, out_en_q};
				`TCH_OFS_STRONG: rdata_d = {{(8-N){1'b0}}, strong_q};
				`TCH_OFS_NOISE: rdata_d = noise_q;
				`TCH_OFS_BUCKET: rdata_d = bucket_q;
				default: begin
				end
			endcase
			for (int i = 0; i < N; i++) begin
				if (reg_addr == LSEL_OFS[i]) begin
					rdata_d = lsel_q[i];
				end
				if (reg_addr == LIN_OFS[i]) begin
					rdata_d = lin_q[i];
				end
			end
		end
	end

	// Pin drive
	always_comb begin
		for (int i = 0; i < N; i++) begin
			pin_out_d[i] = lsel_q[i][`TCH_BIT_LOGIC_EN] ? logic_res[i]
				: out_level_q[i];
		end
		pin_oe_n_d = ~out_en_q;
		pin_strong_d = strong_q & out_en_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= tch_pkg::TCH_NORMAL;
			out_level_q <= RST_OUT_LEVEL[N-1:0];
			sense_en_q <= RST_SENSE_EN[N-1:0];
			out_en_q <= RST_OUT_EN[N-1:0];
			strong_q <= RST_STRONG[N-1:0];
			for (int i = 0; i < N; i++) begin
				lsel_q[i] <= `TCH_RST_LSEL;
				lin_q[i] <= LIN_RST[i];
			end
			noise_q <= `TCH_RST_NOISE;
			bucket_q <= `TCH_RST_BUCKET;
			rdata_q <= 8'h00;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_out_q <= RST_OUT_LEVEL[N-1:0];
			pin_oe_n_q <= ~RST_OUT_EN[N-1:0];
			pin_strong_q <= RST_STRONG[N-1:0] & RST_OUT_EN[N-1:0];
		end else begin
			mode_q <= mode_d;
			out_level_q <= out_level_d;
			sense_en_q <= sense_en_d;
			out_en_q <= out_en_d;
			strong_q <= strong_d;
			lsel_q <= lsel_d;
			lin_q <= lin_d;
			noise_q <= noise_d;
			bucket_q <= bucket_d;
			rdata_q <= rdata_d;
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
			pin_out_q <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
			pin_strong_q <= pin_strong_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign pin_out = pin_out_q;
	assign pin_oe_n = pin_oe_n_q;
	assign pin_strong = pin_strong_q;
	assign setup_mode = mode_q[1];

	// Baseline trackers see only enabled sensors
	tch_trk_if #(.N(N), .W(W)) trk_bus ();
	assign trk_bus.raw = raw_count;
	assign trk_bus.valid = raw_valid;
	assign trk_bus.enable = sense_en_q;
	assign trk_bus.noise_limit = noise_q;
	assign trk_bus.bucket_limit = bucket_q;
	assign baseline = trk_bus.baseline;

	tch_baseline #(.N(N), .W(W)) u_baseline (
		.clk(clk),
		.rst(rst),
		.t(trk_bus)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_level_write: assert property (
		(reg_wr && reg_addr == `TCH_OFS_OUT_LEVEL && !lsel_q[0][`TCH_BIT_LOGIC_EN])
			|=> !lsel_q[0][`TCH_BIT_LOGIC_EN] ##1 pin_out_q[0] == $past(reg_wdata[0], 2))
		else $error("output level write did not reach the pin");
	a_level_ignored: assert property (
		(reg_wr && reg_addr == `TCH_OFS_OUT_LEVEL && lsel_q[0][`TCH_BIT_LOGIC_EN])
			|=> out_level_q[0] == $past(out_level_q[0]))
		else $error("logic-driven output took a level write");
	a_setup_only: assert property (
		(mode_q != tch_pkg::TCH_SETUP)
			|=> $stable(sense_en_q) && $stable(out_en_q) && $stable(strong_q))
		else $error("setup-only register changed in normal mode");
	a_oe_follow: assert property (
		reg_wr && reg_addr == `TCH_OFS_OUT_EN && in_setup
			|=> ##1 pin_oe_n_q == ~$past(reg_wdata[N-1:0], 2))
		else $error("output enable did not reach the pin drive");
	a_strong_gated: assert property (
		!out_en_q[0] |=> !pin_strong_q[0])
		else $error("strong drive on a disabled output");
	a_lsel_discard: assert property (
		(reg_wr && reg_addr == `TCH_OFS_LSEL0 && !out_en_q[0]) |=> $stable(lsel_q[0]))
		else $error("logic select written while output disabled");
	a_or_drive: assert property (
		(lsel_q[0][`TCH_BIT_LOGIC_EN] && lsel_q[0][1:0] == 2'b00
			&& |(touch_state & sense_en_q & lin_q[0][N-1:0])) |=> pin_out_q[0])
		else $error("OR of touched inputs did not drive the pin high");
	a_inv_and: assert property (
		(lsel_q[0][`TCH_BIT_LOGIC_EN] && lsel_q[0][1:0] == 2'b11
			&& (lin_q[0][N-1:0] & ~(touch_state & sense_en_q)) == '0) |=> !pin_out_q[0])
		else $error("inverted AND did not drive the pin low");
	a_setup_cmd: assert property (
		(reg_wr && reg_addr == `TCH_OFS_CMD && reg_wdata == `TCH_CMD_SETUP)
			|=> setup_mode)
		else $error("setup command did not enter setup mode");
	a_status_read: assert property (
		(reg_rd && reg_addr == `TCH_OFS_STATUS)
			|=> reg_rdata == {{(8-N){1'b0}}, $past(pin_s2_q)})
		else $error("status read did not show the pin levels");
endmodule // tch_gpo_top

// ### tch_host_model.sv
/*
 * Host side of the register port: byte writes and reads, one at a time.
 * Assumes the block samples reg_wr and reg_rd on the rising edge of clk.
 */
`timescale 1ns/100ps
`include "tch_map.svh"
module tch_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One idle cycle between strobes keeps each strobe a single pulse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask

	// Setup before setup-only writes; thresholds kept in range by callers
	task automatic enter_setup();
		wr(`TCH_OFS_CMD, `TCH_CMD_SETUP);
	endtask

	// Enabling an output always comes with its strong drive bit
	task automatic set_outputs(input logic [7:0] en);
		wr(`TCH_OFS_OUT_EN, en);
		wr(`TCH_OFS_STRONG, en);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask
endmodule // tch_host_model

// ### tch_map.svh
/*
 * Register offsets, reset values, field positions and command codes of the
 * touch output logic block. Assumes byte-wide registers on an 8-bit index.
 */
`ifndef TCH_MAP_SVH
`define TCH_MAP_SVH

`define TCH_OFS_STATUS 8'h00
`define TCH_OFS_OUT_LEVEL 8'h04
`define TCH_OFS_SENSE_EN 8'h07
`define TCH_OFS_OUT_EN 8'h08
`define TCH_OFS_STRONG 8'h11
`define TCH_OFS_LSEL0 8'h1C
`define TCH_OFS_LIN0 8'h1E
`define TCH_OFS_LSEL1 8'h21
`define TCH_OFS_LIN1 8'h23
`define TCH_OFS_NOISE 8'h4E
`define TCH_OFS_BUCKET 8'h4F
`define TCH_OFS_CMD 8'hA0

`define TCH_RST_OUT_LEVEL 8'h03
`define TCH_RST_SENSE_EN 8'h03
`define TCH_RST_OUT_EN 8'h03
`define TCH_RST_STRONG 8'h03
`define TCH_RST_LSEL 8'h00
`define TCH_RST_LIN0 8'h01
`define TCH_RST_LIN1 8'h02
`define TCH_RST_NOISE 8'h28
`define TCH_RST_BUCKET 8'h64

`define TCH_BIT_LOGIC_EN 7
`define TCH_BIT_LOGIC_INV 1
`define TCH_BIT_LOGIC_AND 0
`define TCH_LSEL_MASK 8'h83

`define TCH_CMD_NORMAL 8'h07
`define TCH_CMD_SETUP 8'h08

`endif

// ### tch_pkg.sv
/*
 * Types shared by the touch output logic block.
 * Assumes the constants of tch_map.svh for all numeric values other than the mode encodings defined here.
 */
package tch_pkg;
	typedef enum logic [1:0] {
		TCH_NORMAL = 2'b01,
		TCH_SETUP = 2'b10
	} tch_mode_t;

	typedef logic [7:0] tch_byte_t;
endpackage

// ### tch_trk_if.sv
/*
 * Carrier between the register block and the baseline trackers.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface tch_trk_if #(
	parameter int N = 2,
	parameter int W = 16
);
	logic [N*W-1:0] raw;
	logic [N-1:0] valid;
	logic [N-1:0] enable;
	tch_pkg::tch_byte_t noise_limit;
	tch_pkg::tch_byte_t bucket_limit;
	logic [N*W-1:0] baseline;

	modport ctrl (output raw, output valid, output enable, output noise_limit,
		output bucket_limit, input baseline);
	modport trk (input raw, input valid, input enable, input noise_limit,
		input bucket_limit, output baseline);
endinterface

// ### touch_output_logic_config_tb_top.sv
/*
 * Self-checking bench for the touch output logic block.
 * Assumes the host model above and a pin wire that floats when undriven.
 */
`timescale 1ns/100ps
`include "tch_map.svh"
module touch_output_logic_config_tb_top;
	logic clk;
	logic rst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [1:0] touch_state;
	logic [31:0] raw_count;
	logic [1:0] raw_valid;
	logic [31:0] baseline;
	logic [1:0] pin_in;
	logic [1:0] pin_out;
	logic [1:0] pin_oe_n;
	logic [1:0] pin_strong;
	logic setup_mode;
	logic [1:0] flt_q;
	logic [7:0] d;
	int n_errors;
	int cmp_count;
	int cycles;
	// Address beside its expected reset read value
	localparam logic [15:0] ROWS [11] = '{
		{`TCH_OFS_SENSE_EN, 8'h03}, {`TCH_OFS_OUT_EN, 8'h03}, {`TCH_OFS_STRONG, 8'h03},
		{`TCH_OFS_LSEL0, 8'h00}, {`TCH_OFS_LIN0, 8'h01}, {`TCH_OFS_LSEL1, 8'h00},
		{`TCH_OFS_LIN1, 8'h02}, {`TCH_OFS_NOISE, 8'h28}, {`TCH_OFS_BUCKET, 8'h64},
		{`TCH_OFS_OUT_LEVEL, 8'h00}, {8'h55, 8'h00}};

	// Undriven pin shows a changing level so a stale value cannot pass
	assign pin_in = (pin_oe_n & flt_q) | (~pin_oe_n & pin_out);

	tch_gpo_top #(.N(2), .W(16)) i_tch_gpo_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.touch_state(touch_state), .raw_count(raw_count), .raw_valid(raw_valid),
		.baseline(baseline), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_strong(pin_strong), .setup_mode(setup_mode));

	tch_host_model i_tch_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		flt_q <= ~flt_q;
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic smp(input logic [15:0] r0);
		@(posedge clk);
		#1 raw_count = {16'h0064, r0};
		raw_valid = 2'b11;
		@(posedge clk);
		#1 raw_valid = 2'b00;
		settle();
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		touch_state = 2'b00;
		raw_count = 32'h0000_0000;
		raw_valid = 2'b00;
		flt_q = 2'b01;
		n_errors = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		chk("pins", {pin_out, pin_oe_n, pin_strong, 1'b0, setup_mode}, 8'hCC);
		foreach (ROWS[i]) begin
			i_tch_host_model.rd(ROWS[i][15:8], d);
			chk("reset read", d, ROWS[i][7:0]);
		end
		$display("reset test done");
		i_tch_host_model.wr(`TCH_OFS_OUT_EN, 8'h00);
		i_tch_host_model.rd(`TCH_OFS_OUT_EN, d);
		chk("normal out_en", d, 8'h03);
		i_tch_host_model.wr(`TCH_OFS_OUT_LEVEL, 8'h01);
		settle();
		chk("level", pin_out, 2'b01);
		settle();
		i_tch_host_model.rd(`TCH_OFS_STATUS, d);
		chk("status", d, 8'h01);
		$display("normal test done");
		i_tch_host_model.enter_setup();
		settle();
		chk("setup", setup_mode, 1'b1);
		i_tch_host_model.set_outputs(8'h01);
		settle();
		chk("oe_n", pin_oe_n, 2'b10);
		chk("strong", pin_strong, 2'b01);
		i_tch_host_model.wr(`TCH_OFS_STRONG, 8'h03);
		settle();
		chk("strong gated", pin_strong, 2'b01);
		i_tch_host_model.wr(`TCH_OFS_LSEL1, 8'h81);
		i_tch_host_model.rd(`TCH_OFS_LSEL1, d);
		chk("lsel1 dropped", d, 8'h00);
		$display("setup test done");
		i_tch_host_model.wr(`TCH_OFS_LIN0, 8'h03);
		i_tch_host_model.wr(`TCH_OFS_LSEL0, 8'h83);
		touch_state = 2'b11;
		settle();
		chk("inv and 11", pin_out[0], 1'b0);
		touch_state = 2'b01;
		settle();
		chk("inv and 01", pin_out[0], 1'b1);
		i_tch_host_model.wr(`TCH_OFS_LSEL0, 8'h80);
		settle();
		chk("or 01", pin_out[0], 1'b1);
		touch_state = 2'b00;
		i_tch_host_model.wr(`TCH_OFS_OUT_LEVEL, 8'h00);
		settle();
		chk("level ignored", pin_out[0], 1'b0);
		// Dropping the logic shows the stored level, which that write must not have cleared
		i_tch_host_model.wr(`TCH_OFS_LSEL0, 8'h00);
		settle();
		chk("level kept", pin_out, 2'b01);
		$display("logic test done");
		i_tch_host_model.wr(`TCH_OFS_SENSE_EN, 8'h01);
		i_tch_host_model.wr(`TCH_OFS_NOISE, 8'h0A);
		i_tch_host_model.wr(`TCH_OFS_BUCKET, 8'h0C);
		smp(16'h0064);
		chk("seed", baseline, 32'h0000_0064);
		smp(16'h0078);
		chk("noisy", baseline, 32'h0000_0064);
		smp(16'h0069);
		smp(16'h0069);
		chk("bucket 10", baseline, 32'h0000_0064);
		smp(16'h0069);
		chk("bucket 15", baseline, 32'h0000_0065);
		$display("baseline test done");
		i_tch_host_model.wr(`TCH_OFS_OUT_EN, 8'h00);
		i_tch_host_model.wr(`TCH_OFS_LSEL0, 8'h81);
		i_tch_host_model.rd(`TCH_OFS_LSEL0, d);
		chk("lsel0 dropped", d, 8'h00);
		chk("strong off", pin_strong, 2'b00);
		i_tch_host_model.wr(`TCH_OFS_CMD, `TCH_CMD_NORMAL);
		i_tch_host_model.wr(`TCH_OFS_SENSE_EN, 8'h03);
		i_tch_host_model.rd(`TCH_OFS_SENSE_EN, d);
		chk("normal sense_en", {setup_mode, d}, 9'h001);
		$display("mode test done");
		conclude();
	end
endmodule // touch_output_logic_config_tb_top
